// File: dv/chipset_model.sv
// chipset model driving the ratio straps and the stop request
`timescale 1ns/1ns
`default_nettype none
module chipset_model
(
    // orders from the bench
    input  wire logic       wantStop,
    input  wire logic [1:0] strapCode,
    // pins toward the block
    output logic            bus_ratio_strap_hi,
    output logic            bus_ratio_strap_lo,
    output logic            stop_clock_request_n
);
    // request active low
    // line is driven high while no stop is wanted
    assign stop_clock_request_n = !wantStop;
    assign {bus_ratio_strap_hi, bus_ratio_strap_lo} = strapCode;
endmodule : chipset_model
`default_nettype wire

// File: dv/core_bus_ratio_and_stop_clock_checker.sv
// assertions on the ports of the ratio and stop clock block
`timescale 1ns/1ns
`default_nettype none
module core_bus_ratio_and_stop_clock_checker
(
    // clock, reset and inputs
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       bus_ratio_strap_hi,
    input wire logic       bus_ratio_strap_lo,
    input wire logic       stop_clock_request_n,
    input wire logic       instrBoundary,
    input wire logic       intrPending,
    input wire logic       grantCycleDone,
    input wire logic       extSnoopReq,
    input wire logic       ipSnoopReq,
    // outputs watched
    input wire logic [2:0] ratioNum,
    input wire logic [2:0] ratioDen,
    input wire logic       coreHalt,
    input wire logic       grantCycleReq,
    input wire logic       coreClkEnable,
    input wire logic       snoopServe
);
    // -----------------------------------------------
    // expected ratio, numerator over denominator
    // -----------------------------------------------
    function automatic logic [5:0] dec(input logic h, input logic l);
        case ({h, l})
            2'h1: dec = 6'h0B;
            2'h0: dec = 6'h15;
            2'h2: dec = 6'h0A;
            default: dec = 6'h13;
        endcase
    endfunction : dec

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    ratio_decode_a: assert property ($fell(srst) |=>
        {ratioNum, ratioDen} == dec($past(bus_ratio_strap_hi),
        $past(bus_ratio_strap_lo))) else $error("ratio not decoded");
    ratio_hold_a: assert property (!$fell(srst) |=>
        $stable({ratioNum, ratioDen})) else $error("ratio moved");
    stop_honoured_a: assert property ((!stop_clock_request_n &&
        instrBoundary && !intrPending && coreClkEnable)[*8] |=> coreHalt)
        else $error("stop request ignored");
    halt_boundary_a: assert property ($rose(coreHalt) |->
        $past(instrBoundary) && !$past(intrPending))
        else $error("halt off boundary");
    grant_start_a: assert property ($rose(coreHalt) |->
        $rose(grantCycleReq)) else $error("no grant cycle");
    grant_hold_a: assert property (grantCycleReq &&
        !grantCycleDone |=> grantCycleReq && coreHalt)
        else $error("grant dropped early");
    grant_end_a: assert property (grantCycleReq &&
        grantCycleDone |=> !grantCycleReq && !coreClkEnable)
        else $error("clock not gated");
    snoop_serve_a: assert property (!coreClkEnable &&
        !stop_clock_request_n && !$past(stop_clock_request_n, 4) &&
        (extSnoopReq || ipSnoopReq) |=> snoopServe && !coreClkEnable)
        else $error("snoop not served");

    // main scenarios reached
    cover property ($rose(grantCycleReq));
    cover property ($rose(snoopServe));
    cover property (grantCycleReq && grantCycleDone);
endmodule : core_bus_ratio_and_stop_clock_checker
bind core_bus_ratio_and_stop_clock core_bus_ratio_and_stop_clock_checker
    chk
    (
        .clk                  (clk),
        .srst                 (srst),
        .bus_ratio_strap_hi   (bus_ratio_strap_hi),
        .bus_ratio_strap_lo   (bus_ratio_strap_lo),
        .stop_clock_request_n (stop_clock_request_n),
        .instrBoundary        (instrBoundary),
        .intrPending          (intrPending),
        .grantCycleDone       (grantCycleDone),
        .extSnoopReq          (extSnoopReq),
        .ipSnoopReq           (ipSnoopReq),
        .ratioNum             (ratioNum),
        .ratioDen             (ratioDen),
        .coreHalt             (coreHalt),
        .grantCycleReq        (grantCycleReq),
        .coreClkEnable        (coreClkEnable),
        .snoopServe           (snoopServe)
    );
`default_nettype wire

// File: dv/core_bus_ratio_and_stop_clock_tb_top.sv
// self-checking bench for the ratio and stop clock block
`timescale 1ns/1ns
`default_nettype none
module core_bus_ratio_and_stop_clock_tb_top;
    // clock, reset and core side stimulus
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic instrBoundary = 1'b0, intrPending = 1'b0, grantCycleDone = 1'b0;
    logic extSnoopReq = 1'b0, ipSnoopReq = 1'b0;
    logic wantStop = 1'b0;
    logic [1:0] strapCode = 2'h0;
    wire logic bus_ratio_strap_hi, bus_ratio_strap_lo, stop_clock_request_n;
    logic [2:0] ratioNum, ratioDen;
    logic coreHalt, grantCycleReq, coreClkEnable, snoopServe;
    // status: halt 8, grant 4, clock enable 2, snoop 1
    wire logic [5:0] st = {2'h0, coreHalt, grantCycleReq, coreClkEnable,
        snoopServe};
    int numErrors = 0, nChecks = 0, cycles = 0;
    // rows: straps in [7:6], numerator and denominator below
    logic [7:0] rows [4] = '{8'h4B, 8'h15, 8'h8A, 8'hD3};

    core_bus_ratio_and_stop_clock dut
    (
        .clk                  (clk),
        .srst                 (srst),
        .bus_ratio_strap_hi   (bus_ratio_strap_hi),
        .bus_ratio_strap_lo   (bus_ratio_strap_lo),
        .stop_clock_request_n (stop_clock_request_n),
        .instrBoundary        (instrBoundary),
        .intrPending          (intrPending),
        .grantCycleDone       (grantCycleDone),
        .extSnoopReq          (extSnoopReq),
        .ipSnoopReq           (ipSnoopReq),
        .ratioNum             (ratioNum),
        .ratioDen             (ratioDen),
        .coreHalt             (coreHalt),
        .grantCycleReq        (grantCycleReq),
        .coreClkEnable        (coreClkEnable),
        .snoopServe           (snoopServe)
    );
    chipset_model chipset (.wantStop(wantStop), .strapCode(strapCode),
        .bus_ratio_strap_hi(bus_ratio_strap_hi),
        .bus_ratio_strap_lo(bus_ratio_strap_lo),
        .stop_clock_request_n(stop_clock_request_n));

    always #4 clk = !clk;
    // hang guard, far above the hundred or so cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            numErrors++;
            conclude();
        end
    end

    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic conclude();
        $display("checks %0d mismatches %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    initial
    begin
        // every strap pair, each behind its own reset
        foreach (rows[i])
        begin
            srst = 1'b1;
            strapCode = rows[i][7:6];
            tick(8);
            srst = 1'b0;
            tick(2);
            check({ratioNum, ratioDen}, rows[i][5:0]);
        end
        $display("test strap decode done");
        // ratio must ignore straps moving after release
        strapCode = 2'h1;
        tick(3);
        check({ratioNum, ratioDen}, 6'h13);
        $display("test strap hold done");
        // plain stop, grant, gated clock, both snoop kinds
        instrBoundary = 1'b1;
        wantStop = 1'b1;
        tick(10);
        // core clock keeps running until the grant cycle is done
        check(st, 6'h0E);
        grantCycleDone = 1'b1;
        tick(1);
        grantCycleDone = 1'b0;
        tick(1);
        check(st, 6'h08);
        extSnoopReq = 1'b1;
        tick(2);
        check(st, 6'h09);
        extSnoopReq = 1'b0;
        ipSnoopReq = 1'b1;
        tick(2);
        check(st, 6'h09);
        ipSnoopReq = 1'b0;
        wantStop = 1'b0;
        tick(6);
        check(st, 6'h02);
        $display("test stop grant done");
        // interrupt first, then the request is dropped
        intrPending = 1'b1;
        wantStop = 1'b1;
        tick(10);
        check(st, 6'h02);
        wantStop = 1'b0;
        tick(6);
        intrPending = 1'b0;
        tick(4);
        check(st, 6'h02);
        // no boundary yet, so nothing halts until it comes
        instrBoundary = 1'b0;
        wantStop = 1'b1;
        tick(10);
        check(st, 6'h02);
        instrBoundary = 1'b1;
        tick(2);
        check(st, 6'h0E);
        $display("test awkward stop done");
        conclude();
    end
endmodule : core_bus_ratio_and_stop_clock_tb_top
`default_nettype wire

// File: hdl/clock_ctrl_pkg.sv
// constants and types shared by the clock control block
//
// Operation
// (RULE1) decode two straps into bus/core ratio
// (RULE2) low stop request asks core clock halt
// (RULE3) halt at next boundary, interrupts first
// (RULE4) run stop-grant acknowledge cycle after halting
// (RULE5) keep serving snoops while clock stopped
// (RULE6) latch straps at reset release, hold
`default_nettype none
package clock_ctrl_pkg;

    // ------------------------------------------------------------
    // ratio encodings: numerator over denominator of bus/core
    // ------------------------------------------------------------
    localparam logic [1:0] STRAP_ONE_THIRD   = 2'h1;
    localparam logic [1:0] STRAP_TWO_FIFTHS  = 2'h0;
    localparam logic [1:0] STRAP_ONE_HALF    = 2'h2;
    localparam logic [1:0] STRAP_TWO_THIRDS  = 2'h3;

    localparam logic [2:0] RATIO_NUM_ONE     = 3'h1;
    localparam logic [2:0] RATIO_NUM_TWO     = 3'h2;
    localparam logic [2:0] RATIO_DEN_TWO     = 3'h2;
    localparam logic [2:0] RATIO_DEN_THREE   = 3'h3;
    localparam logic [2:0] RATIO_DEN_FIVE    = 3'h5;

    // reset value of the latched strap pair (1/2)
    localparam logic [1:0] STRAP_RESET       = 2'h2;

    // ------------------------------------------------------------
    // stop clock sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT_BOUNDARY,
        ST_GRANT_CYCLE,
        ST_STOPPED,
        ST_SNOOP
    } stop_state_e;

endpackage : clock_ctrl_pkg
`default_nettype wire

// File: hdl/core_bus_ratio_and_stop_clock.sv
// bus/core ratio select and stop clock sequencer
`timescale 1ns/1ns
`default_nettype none
module core_bus_ratio_and_stop_clock
(
    // clock and synchronous reset
    input  wire logic       clk,
    input  wire logic       srst,
    // straps and stop request from the chipset
    input  wire logic       bus_ratio_strap_hi,
    input  wire logic       bus_ratio_strap_lo,
    input  wire logic       stop_clock_request_n,
    // core handshake
    input  wire logic       instrBoundary,
    input  wire logic       intrPending,
    input  wire logic       grantCycleDone,
    // snoop requests
    input  wire logic       extSnoopReq,
    input  wire logic       ipSnoopReq,
    // selected ratio
    output logic [2:0]      ratioNum,
    output logic [2:0]      ratioDen,
    // stop clock outputs
    output logic            coreHalt,
    output logic            grantCycleReq,
    output logic            coreClkEnable,
    output logic            snoopServe
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic stopReqLevel_n;   // qualified stop request, active low

    pin_sync u_stop_sync
    (
        .clk      (clk),
        .srst     (srst),
        .pinIn    (stop_clock_request_n),
        .levelOut (stopReqLevel_n)
    );

    // ------------------------------------------------------------
    // ratio decode
    // ------------------------------------------------------------
    function automatic logic [5:0] decode_ratio(input logic [1:0] s);
        logic [5:0] r;
        // fall back to 1/2, the same ratio that reset shows
        r = {clock_ctrl_pkg::RATIO_NUM_ONE, clock_ctrl_pkg::RATIO_DEN_TWO};
        unique case (s)
            clock_ctrl_pkg::STRAP_ONE_THIRD:
                r = {clock_ctrl_pkg::RATIO_NUM_ONE,
                     clock_ctrl_pkg::RATIO_DEN_THREE};
            clock_ctrl_pkg::STRAP_TWO_FIFTHS:
                r = {clock_ctrl_pkg::RATIO_NUM_TWO,
                     clock_ctrl_pkg::RATIO_DEN_FIVE};
            clock_ctrl_pkg::STRAP_ONE_HALF:
                r = {clock_ctrl_pkg::RATIO_NUM_ONE,
                     clock_ctrl_pkg::RATIO_DEN_TWO};
            clock_ctrl_pkg::STRAP_TWO_THIRDS:
                r = {clock_ctrl_pkg::RATIO_NUM_TWO,
                     clock_ctrl_pkg::RATIO_DEN_THREE};
        endcase
        return r;
    endfunction : decode_ratio

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    logic [1:0] strap_q;      // latched strap pair
    logic [1:0] strap_d;
    logic       inReset_q;    // high during reset, marks the release
    logic       inReset_d;
    logic [2:0] ratioNum_q;
    logic [2:0] ratioNum_d;
    logic [2:0] ratioDen_q;
    logic [2:0] ratioDen_d;

    // straps are synchronous to the bus clock, so no synchroniser;
    // they must only be steady across the release edge
    always_comb
    begin
        strap_d    = strap_q;
        inReset_d  = 1'b0;
        // (RULE6) capture at release
        if (inReset_q)
        begin
            strap_d = {bus_ratio_strap_hi, bus_ratio_strap_lo};
        end
        // (RULE1) strap to ratio
        {ratioNum_d, ratioDen_d} = decode_ratio(strap_d);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            strap_q    <= clock_ctrl_pkg::STRAP_RESET;
            inReset_q  <= 1'b1;
            ratioNum_q <= clock_ctrl_pkg::RATIO_NUM_ONE;
            ratioDen_q <= clock_ctrl_pkg::RATIO_DEN_TWO;
        end
        else
        begin
            strap_q    <= strap_d;
            inReset_q  <= inReset_d;
            ratioNum_q <= ratioNum_d;
            ratioDen_q <= ratioDen_d;
        end
    end

    // ------------------------------------------------------------
    // stop clock sequencer
    // ------------------------------------------------------------
    clock_ctrl_pkg::stop_state_e state_q;   // sequencer state
    clock_ctrl_pkg::stop_state_e state_d;
    logic halt_q;
    logic halt_d;
    logic grant_q;
    logic grant_d;
    logic clkEn_q;
    logic clkEn_d;
    logic snoop_q;
    logic snoop_d;
    logic stopReq;             // request seen, active high
    logic snoopAny;            // any snoop asking

    assign stopReq  = ~stopReqLevel_n;
    assign snoopAny = extSnoopReq | ipSnoopReq;

    always_comb
    begin
        state_d = state_q;
        halt_d  = halt_q;
        grant_d = 1'b0;
        clkEn_d = clkEn_q;
        snoop_d = 1'b0;
        unique case (state_q)
            clock_ctrl_pkg::ST_RUN:
            begin
                // (RULE2) low level is a request
                if (stopReq)
                begin
                    state_d = clock_ctrl_pkg::ST_WAIT_BOUNDARY;
                end
            end
            clock_ctrl_pkg::ST_WAIT_BOUNDARY:
            begin
                // (RULE3) boundary, interrupt first
                if (!stopReq)
                begin
                    state_d = clock_ctrl_pkg::ST_RUN;
                end
                else if (instrBoundary && !intrPending)
                begin
                    state_d = clock_ctrl_pkg::ST_GRANT_CYCLE;
                    halt_d  = 1'b1;
                    grant_d = 1'b1;
                end
            end
            clock_ctrl_pkg::ST_GRANT_CYCLE:
            begin
                // (RULE4) acknowledge cycle held until done
                grant_d = 1'b1;
                if (grantCycleDone)
                begin
                    grant_d = 1'b0;
                    clkEn_d = 1'b0;
                    state_d = clock_ctrl_pkg::ST_STOPPED;
                end
            end
            clock_ctrl_pkg::ST_STOPPED:
            begin
                // (RULE5) serve snoops, clock stays off
                if (!stopReq)
                begin
                    state_d = clock_ctrl_pkg::ST_RUN;
                    halt_d  = 1'b0;
                    clkEn_d = 1'b1;
                end
                else if (snoopAny)
                begin
                    snoop_d = 1'b1;
                    state_d = clock_ctrl_pkg::ST_SNOOP;
                end
            end
            clock_ctrl_pkg::ST_SNOOP:
            begin
                // (RULE5) snoop served without core clock
                snoop_d = snoopAny;
                if (!snoopAny)
                begin
                    state_d = clock_ctrl_pkg::ST_STOPPED;
                end
            end
            default:
            begin
                state_d = clock_ctrl_pkg::ST_RUN;
                halt_d  = 1'b0;
                clkEn_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= clock_ctrl_pkg::ST_RUN;
            halt_q  <= 1'b0;
            grant_q <= 1'b0;
            clkEn_q <= 1'b1;
            snoop_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            halt_q  <= halt_d;
            grant_q <= grant_d;
            clkEn_q <= clkEn_d;
            snoop_q <= snoop_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign ratioNum      = ratioNum_q;
    assign ratioDen      = ratioDen_q;
    assign coreHalt      = halt_q;
    assign grantCycleReq = grant_q;
    assign coreClkEnable = clkEn_q;
    assign snoopServe    = snoop_q;

endmodule : core_bus_ratio_and_stop_clock
`default_nettype wire

// File: hdl/pin_sync.sv
// three-flop synchroniser with agreement qualification
`timescale 1ns/1ns
`default_nettype none
module pin_sync
(
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // asynchronous pin and its qualified level
    input  wire logic pinIn,
    output logic      levelOut
);

    // ------------------------------------------------------------
    // shift chain
    // ------------------------------------------------------------
    logic       meta_q;      // first stage, read only by stage two
    logic       stage2_q;    // second stage
    logic       stage3_q;    // third stage
    logic       level_q;     // qualified level
    logic       level_d;

    // change counts once stages two and three agree
    always_comb
    begin
        level_d = level_q;
        if (stage2_q == stage3_q)
        begin
            level_d = stage2_q;
        end
    end

    // reset to one: pins here idle high (pulled up)
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_q   <= 1'b1;
            stage2_q <= 1'b1;
            stage3_q <= 1'b1;
            level_q  <= 1'b1;
        end
        else
        begin
            meta_q   <= pinIn;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
            level_q  <= level_d;
        end
    end

    assign levelOut = level_q;

endmodule : pin_sync
`default_nettype wire
